// ### hw/pib_irq_bank.sv
// Purpose: Peripheral interrupt enable and flag registers with request.
// Assumes: Event inputs are one-cycle pulses synchronous to ref_clk.
// Notes:   Zero wait states; reads see the value a pending write makes.
//
// Implementation choice: the AHB-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module pib_irq_bank
   import pib_pkg::*;
#(
   parameter bit HAS_CONVERTER = 1'b1
)
(
   // Clock and reset
   input  wire logic        ref_clk,
   input  wire logic        sys_rst,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [31:0] haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic [1:0]       hresp,
   // Peripheral events
   input  wire logic        displayEvt,
   input  wire logic        convDoneEvt,
   input  wire logic        serialDoneEvt,
   input  wire logic        capcmpEvt,
   input  wire logic [1:0]  capcmpMode,
   input  wire logic        periodMatchEvt,
   input  wire logic        timer16OvfEvt,
   // Interrupt request to the core
   output logic             periphIrq
);
   // ****************************************************************
   // Bus front end
   // ****************************************************************
   logic        rdAcc;
   logic        wrPend_q;
   logic [7:0]  wrAddr_q;
   logic        wrFlags;
   logic        wrEnables;
   logic        wrGctrl;
   logic [7:0]  evtVec;
   logic [7:0]  flags_d;
   logic [7:0]  flags_q;
   logic [7:0]  enables_d;
   logic [7:0]  enables_q;
   logic [7:0]  implMask;
   logic        gie_d;
   logic        gie_q;
   logic        periph_group_enable_d;
   logic        periph_group_enable_q;
   logic [31:0] hrdata_d;
   logic [31:0] hrdata_q;
   logic        irq_d;
   logic        irq_q;

   pib_ahb_front u_front
   (
      .ref_clk  (ref_clk),
      .sys_rst  (sys_rst),
      .hsel     (hsel),
      .htrans   (htrans),
      .hwrite   (hwrite),
      .hready   (hready),
      .haddrLow (haddr[7:0]),
      .rdAcc    (rdAcc),
      .wrPend_q (wrPend_q),
      .wrAddr_q (wrAddr_q)
   );

   // Data-phase write decode; unmapped addresses are ignored.
   always_comb
   begin
      wrFlags   = 1'b0;
      wrEnables = 1'b0;
      wrGctrl   = 1'b0;
      if (wrPend_q && wrAddr_q == PIB_OFS_FLAGS)
         wrFlags = 1'b1;
      else if (wrPend_q && wrAddr_q == PIB_OFS_ENABLES)
         wrEnables = 1'b1;
      else if (wrPend_q && wrAddr_q == PIB_OFS_GCTRL)
         wrGctrl = 1'b1;
   end

   // ****************************************************************
   // Flag and enable bits
   // ****************************************************************
   // Event vector in flag bit order; capture/compare idles in PWM mode.
   always_comb
   begin
      evtVec                  = 8'h00;
      evtVec[PIB_BIT_DISPLAY] = displayEvt;
      evtVec[PIB_BIT_CONV]    = convDoneEvt;
      evtVec[PIB_BIT_SERIAL]  = serialDoneEvt;
      evtVec[PIB_BIT_CAPCMP]  = capcmpEvt
                                & (capcmpMode != PIB_CC_PWM);
      evtVec[PIB_BIT_PERIOD]  = periodMatchEvt;
      evtVec[PIB_BIT_TMR16]   = timer16OvfEvt;
   end

   // Bits 5 and 4 are absent; bit 6 exists only with a converter.
   always_comb
   begin
      implMask               = PIB_IMPL_MASK;
      implMask[PIB_BIT_CONV] = HAS_CONVERTER;
   end

   // One sticky cell per flag bit and one per enable bit.
   for (genvar i = 0; i < 8; i++)
   begin : g_bit
      localparam bit BIT_IMPL = (i == PIB_BIT_CONV) ? HAS_CONVERTER
                                                    : PIB_IMPL_MASK[i];
      pib_flag_cell #(.IMPL(BIT_IMPL)) u_flag
      (
         .ref_clk (ref_clk),
         .sys_rst (sys_rst),
         .setEvt  (evtVec[i]),
         .wrEn    (wrFlags),
         .wrVal   (hwdata[i]),
         .bit_d   (flags_d[i]),
         .bit_q   (flags_q[i])
      );
      pib_flag_cell #(.IMPL(BIT_IMPL)) u_enable
      (
         .ref_clk (ref_clk),
         .sys_rst (sys_rst),
         .setEvt  (1'b0),
         .wrEn    (wrEnables),
         .wrVal   (hwdata[i]),
         .bit_d   (enables_d[i]),
         .bit_q   (enables_q[i])
      );
   end

   // ****************************************************************
   // Global enables, read data and request
   // ****************************************************************
   // Global and peripheral-group enables; reads bypass a pending write.
   always_comb
   begin
      gie_d    = wrGctrl ? hwdata[PIB_BIT_GIE] : gie_q;
      periph_group_enable_d   = wrGctrl ? hwdata[PIB_BIT_PERIPH_GROUP_ENABLE] : periph_group_enable_q;
      hrdata_d = hrdata_q;
      if (rdAcc && haddr[7:0] == PIB_OFS_FLAGS)
         hrdata_d = {24'h000000, flags_d & implMask};
      else if (rdAcc && haddr[7:0] == PIB_OFS_ENABLES)
         hrdata_d = {24'h000000, enables_d & implMask};
      else if (rdAcc && haddr[7:0] == PIB_OFS_GCTRL)
         hrdata_d = {24'h000000, gie_d, periph_group_enable_d, 6'h00};
      else if (rdAcc)
         hrdata_d = 32'h00000000;
      // Any enabled pending flag, gated by both global enables.
      irq_d = gie_q & periph_group_enable_q
              & |(flags_q & enables_q & implMask);
   end

   // Registered bus outputs and request.
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         gie_q    <= 1'b0;
         periph_group_enable_q   <= 1'b0;
         hrdata_q <= 32'h00000000;
         irq_q    <= 1'b0;
      end
      else
      begin
         gie_q    <= gie_d;
         periph_group_enable_q   <= periph_group_enable_d;
         hrdata_q <= hrdata_d;
         irq_q    <= irq_d;
      end
   end

   assign hrdata    = hrdata_q;
   assign hreadyout = 1'b1;          // Never stretched; tied OKAY below.
   assign hresp     = PIB_HRESP_OKAY;
   assign periphIrq = irq_q;

   // ****************************************************************
   // Assertions
   // ****************************************************************
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (sys_rst);

   // The request is a register, so both enables stood a cycle before.
   AST_GROUP_GATE: assert property (
      irq_q |-> $past(periph_group_enable_q) && $past(gie_q))
      else $error("Request without both global enables.");

   // Each enabled, pending source raises the request one cycle later.
   AST_DISPLAY_EN: assert property (
      flags_q[7] && enables_q[7] && gie_q && periph_group_enable_q |=> irq_q)
      else $error("Enabled display flag gave no request.");
   AST_CONV_EN: assert property (
      flags_q[6] && enables_q[6] && gie_q && periph_group_enable_q |=> irq_q)
      else $error("Enabled converter flag gave no request.");
   AST_SERIAL_EN: assert property (
      flags_q[3] && enables_q[3] && gie_q && periph_group_enable_q |=> irq_q)
      else $error("Enabled serial flag gave no request.");
   AST_CAPCMP_EN: assert property (
      flags_q[2] && enables_q[2] && gie_q && periph_group_enable_q |=> irq_q)
      else $error("Enabled capture flag gave no request.");
   AST_PERIOD_EN: assert property (
      flags_q[1] && enables_q[1] && gie_q && periph_group_enable_q |=> irq_q)
      else $error("Enabled period flag gave no request.");
   AST_TMR16_EN: assert property (
      flags_q[0] && enables_q[0] && gie_q && periph_group_enable_q |=> irq_q)
      else $error("Enabled overflow flag gave no request.");

   // Without a converter, bit 6 of both registers never holds a one.
   AST_CONV_RSVD: assert property (
      !HAS_CONVERTER |-> !enables_q[6] && !flags_q[6])
      else $error("Reserved converter bit became set.");

   // Absent bits never store a one and never reach the read data.
   AST_UNIMPL_ZERO: assert property (
      hrdata_q[5:4] == 2'h0 && flags_q[5:4] == 2'h0
      && enables_q[5:4] == 2'h0)
      else $error("Unimplemented bits read nonzero.");

   // No enabled pending flag means no request a cycle later.
   AST_NO_MATCH: assert property (
      (flags_q & enables_q) == 8'h00 |=> !irq_q)
      else $error("Request without an enabled flag.");

   // Events set their flags whatever the enables hold.
   AST_EVT_SETS: assert property (
      periodMatchEvt || timer16OvfEvt |=> flags_q[1] || flags_q[0])
      else $error("Event did not set its flag.");
   AST_CONV_SET: assert property (
      convDoneEvt && HAS_CONVERTER |=> flags_q[6])
      else $error("Conversion event lost.");
   AST_CONV_HOLD: assert property (
      flags_q[6] && !wrFlags |=> flags_q[6])
      else $error("Converter flag dropped without a write.");
   AST_DISPLAY_SET: assert property (
      displayEvt |=> flags_q[7] [*1])
      else $error("Display event lost.");

   // A set in the same cycle as a clearing write must win.
   AST_SET_WINS: assert property (
      serialDoneEvt && wrFlags && !hwdata[3] |=> flags_q[3])
      else $error("Serial event lost to a clear.");

   // Capture/compare sets only outside pulse-width mode.
   AST_PWM_IDLE: assert property (
      capcmpEvt && capcmpMode == PIB_CC_PWM
      && !flags_q[2] && !wrFlags |=> !flags_q[2])
      else $error("Capture/compare flag set in PWM mode.");
   AST_CAPCMP_SET: assert property (
      capcmpEvt && capcmpMode != PIB_CC_PWM |=> flags_q[2])
      else $error("Capture/compare event lost.");
   AST_PERIOD_SET: assert property (
      periodMatchEvt |=> flags_q[1])
      else $error("Period match event lost.");
   AST_OVF_SET: assert property (
      timer16OvfEvt |=> flags_q[0])
      else $error("Timer overflow event lost.");

   // Reset leaves both registers and the request cleared.
   AST_RESET_ZERO: assert property (
      @(posedge ref_clk) disable iff (1'b0)
      sys_rst |=> flags_q == 8'h00 && enables_q == 8'h00 && !irq_q)
      else $error("Bank not zero after reset.");

   // A read two cycles after a write's data phase sees the new value.
   AST_READBACK: assert property (
      wrEnables ##2 (rdAcc && haddr[7:0] == PIB_OFS_ENABLES)
      |=> hrdata_q[7:0] == enables_q)
      else $error("Enable readback mismatch.");

   // Main scenarios: request rise, clear, set against clear, PWM drop.
   COV_IRQ_RISE:  cover property (!irq_q ##1 irq_q);
   COV_CLEAR:     cover property (flags_q[0] && wrFlags ##1 !flags_q[0]);
   COV_SET_CLEAR: cover property (capcmpEvt && wrFlags && !hwdata[2]);
   COV_PWM_DROP:  cover property (capcmpEvt && capcmpMode == PIB_CC_PWM);
endmodule // pib_irq_bank
`default_nettype wire

// ### shared/pib_pkg.sv
// Purpose: Shared constants for the peripheral interrupt enable/flag bank.
// Assumes: AHB-Lite register access, 32-bit data, byte addresses.
// Notes:   Registers hold 8 bits in the low byte; upper bits read zero.
package pib_pkg;
   // ****************************************************************
   // Register map
   // ****************************************************************
   localparam logic [7:0] PIB_OFS_FLAGS   = 8'h0C;
   localparam logic [7:0] PIB_OFS_ENABLES = 8'h8C;
   localparam logic [7:0] PIB_OFS_GCTRL   = 8'h10;
   // ****************************************************************
   // Field positions
   // ****************************************************************
   localparam int PIB_BIT_DISPLAY = 7;
   localparam int PIB_BIT_CONV    = 6;
   localparam int PIB_BIT_SERIAL  = 3;
   localparam int PIB_BIT_CAPCMP  = 2;
   localparam int PIB_BIT_PERIOD  = 1;
   localparam int PIB_BIT_TMR16   = 0;
   localparam int PIB_BIT_GIE     = 7;
   localparam int PIB_BIT_PERIPH_GROUP_ENABLE    = 6;
   // Implemented bits of both bank registers; bits 5 and 4 are absent.
   localparam logic [7:0] PIB_IMPL_MASK = 8'hCF;
   localparam logic [7:0] PIB_RST_VAL   = 8'h00;
   // ****************************************************************
   // Bus and mode encodings
   // ****************************************************************
   localparam logic [1:0] PIB_HTRANS_NONSEQ = 2'h2;
   localparam logic [1:0] PIB_HTRANS_SEQ    = 2'h3;
   localparam logic [1:0] PIB_HRESP_OKAY    = 2'h0;
   typedef enum logic [1:0]
   {
      PIB_CC_CAPTURE = 2'h0,
      PIB_CC_COMPARE = 2'h1,
      PIB_CC_PWM     = 2'h3
   } pib_ccmode_e;
endpackage

// ### hw/pib_flag_cell.sv
// Purpose: One stored bit that hardware may set and software may write.
// Assumes: Set events and writes are synchronous to ref_clk.
// Notes:   An absent bit stays zero and ignores everything.
`timescale 1ns/1ns
`default_nettype none
module pib_flag_cell
   import pib_pkg::*;
#(
   parameter bit IMPL = 1'b1
)
(
   // Clock and reset
   input  wire logic ref_clk,
   input  wire logic sys_rst,
   // Set and write
   input  wire logic setEvt,
   input  wire logic wrEn,
   input  wire logic wrVal,
   // State
   output logic      bit_d,
   output logic      bit_q
);
   // Next value: a hardware set wins over a software clear.
   always_comb
   begin
      if (!IMPL)
         bit_d = 1'b0;
      else
         bit_d = setEvt | (wrEn ? wrVal : bit_q);
   end

   // The bit clears at reset.
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
         bit_q <= 1'b0;
      else
         bit_q <= bit_d;
   end
endmodule // pib_flag_cell
`default_nettype wire

// ### hw/pib_ahb_front.sv
// Purpose: Captures AHB-Lite address phases for a zero-wait-state slave.
// Assumes: Single word transfers; the slave never stretches a transfer.
// Notes:   Read decode is immediate; writes complete in the data phase.
`timescale 1ns/1ns
`default_nettype none
module pib_ahb_front
   import pib_pkg::*;
(
   // Clock and reset
   input  wire logic       ref_clk,
   input  wire logic       sys_rst,
   // Address phase
   input  wire logic       hsel,
   input  wire logic [1:0] htrans,
   input  wire logic       hwrite,
   input  wire logic       hready,
   input  wire logic [7:0] haddrLow,
   // Decoded strobes
   output logic            rdAcc,
   output logic            wrPend_q,
   output logic [7:0]      wrAddr_q
);
   logic       accept;
   logic       wrPend_d;
   logic [7:0] wrAddr_d;

   // A transfer is taken when selected, active and the bus is ready.
   always_comb
   begin
      accept   = hsel & hready & (htrans == PIB_HTRANS_NONSEQ
                                  | htrans == PIB_HTRANS_SEQ);
      rdAcc    = accept & ~hwrite;
      wrPend_d = accept & hwrite;
      wrAddr_d = wrPend_d ? haddrLow : wrAddr_q;
   end

   // The write address waits one cycle for its data.
   always_ff @(posedge ref_clk)
   begin
      if (sys_rst)
      begin
         wrPend_q <= 1'b0;
         wrAddr_q <= 8'h00;
      end
      else
      begin
         wrPend_q <= wrPend_d;
         wrAddr_q <= wrAddr_d;
      end
   end
endmodule // pib_ahb_front
`default_nettype wire

// ### tb/pib_periph_model.sv
// Purpose: Peripheral event source model for the interrupt bank bench.
// Assumes: Requests come from the bench as one-cycle pulses.
// Notes:   Each request bit except 5 and 4 becomes one event pulse a cycle later.
`timescale 1ns/1ns
`default_nettype none
module pib_periph_model
(
   // Clock
   input  wire logic       ref_clk,
   // Requests from the bench, one bit per flag position
   input  wire logic [7:0] fireReq,
   // Event pulses to the bank
   output logic            displayEvt,
   output logic            convDoneEvt,
   output logic            serialDoneEvt,
   output logic            capcmpEvt,
   output logic            periodMatchEvt,
   output logic            timer16OvfEvt
);
   // Turns each request into a single-cycle event, as a peripheral would.
   always_ff @(posedge ref_clk)
   begin
      displayEvt     <= fireReq[7];
      convDoneEvt    <= fireReq[6];
      serialDoneEvt  <= fireReq[3];
      capcmpEvt      <= fireReq[2];
      periodMatchEvt <= fireReq[1];
      timer16OvfEvt  <= fireReq[0];
   end
endmodule // pib_periph_model
`default_nettype wire

// ### tb/peripheral_irq_enable_flag_bank_tb_top.sv
// Purpose: Self-checking bench for the interrupt enable and flag bank.
// Assumes: Zero-wait AHB-Lite slave; reads return data in the data phase.
// Notes:   Expected read results are queued by the driver and checked by a monitor.
`timescale 1ns/1ns
`default_nettype none
`define CHK(got, exp) \
   begin \
      comparisons++; \
      if ((got) !== (exp)) \
      begin \
         errCount++; \
         $display("[ERR] %0t got %h exp %h", $time, (got), (exp)); \
      end \
   end
module peripheral_irq_enable_flag_bank_tb_top;
   import pib_pkg::*;
   logic        ref_clk, sys_rst, hsel, hwrite, hreadyout, periphIrq;
   logic [31:0] haddr, hwdata, hrdata, seed, v;
   logic [1:0]  htrans, hresp, capcmpMode;
   logic [2:0]  hsize;
   logic [7:0]  fireReq;
   logic        dispE, convE, serE, ccE, perE, ovfE, rdPhase;
   logic [31:0] expQ[$];
   int          errCount, comparisons;
   int          bitTab[6] = '{7, 6, 3, 2, 1, 0};
   // ***************************************************************
   // Design and peripheral model
   // ***************************************************************
   pib_irq_bank DUT (.ref_clk(ref_clk), .sys_rst(sys_rst), .hsel(hsel),
      .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
      .hready(hreadyout), .hwdata(hwdata), .hrdata(hrdata),
      .hreadyout(hreadyout), .hresp(hresp), .displayEvt(dispE),
      .convDoneEvt(convE), .serialDoneEvt(serE), .capcmpEvt(ccE),
      .capcmpMode(capcmpMode), .periodMatchEvt(perE),
      .timer16OvfEvt(ovfE), .periphIrq(periphIrq));
   pib_periph_model peri (.ref_clk(ref_clk), .fireReq(fireReq),
      .displayEvt(dispE), .convDoneEvt(convE), .serialDoneEvt(serE),
      .capcmpEvt(ccE), .periodMatchEvt(perE), .timer16OvfEvt(ovfE));
   // Free-running 100 MHz clock.
   always #5 ref_clk = ~ref_clk;
   // ***************************************************************
   // Tasks
   // ***************************************************************
   // Prints the counts and the verdict, then ends the run.
   task automatic tally_and_finish();
      $display("Mismatches %0d, comparisons %0d", errCount, comparisons);
      if (errCount == 0 && comparisons > 0)
         $display("Run complete: PASS");
      else
         $display("Run complete: FAIL");
      $finish;
   endtask
   // Waits for hready high at a rising edge, with a bound.
   task automatic waitRdy();
      int n;
      n = 0;
      do
      begin
         @(posedge ref_clk);
         n++;
      end while (hreadyout !== 1'b1 && n < 50);
      if (n >= 50)
      begin
         errCount++;
         tally_and_finish();
      end
   endtask
   // One single-word transfer: address phase, then data phase.
   task automatic xfer(input logic wrt, input logic [7:0] a,
                       input logic [31:0] d);
      @(posedge ref_clk);
      hsel   <= 1'b1;
      htrans <= PIB_HTRANS_NONSEQ;
      hwrite <= wrt;
      haddr  <= {24'h000000, a};
      waitRdy();
      htrans <= 2'h0;
      hwdata <= d;
      waitRdy();
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      xfer(1'b1, a, d);
   endtask
   // Queues the expected value, then reads; the monitor compares.
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      expQ.push_back(e);
      xfer(1'b0, a, 32'h00000000);
   endtask
   // Requests event pulses and lets the flags settle.
   task automatic fire(input logic [7:0] m);
      @(posedge ref_clk);
      fireReq <= m;
      @(posedge ref_clk);
      fireReq <= 8'h00;
      repeat (2) @(posedge ref_clk);
   endtask
   // Lets a register change reach the request output, then checks it.
   task automatic irqChk(input logic e);
      repeat (2) @(posedge ref_clk);
      #1 `CHK(periphIrq, e)
   endtask
   function automatic logic [31:0] xs();
      seed ^= seed << 13;
      seed ^= seed >> 17;
      seed ^= seed << 5;
      return seed;
   endfunction
   // Compares read data at the edge that ends each read data phase.
   always @(posedge ref_clk)
   begin : mon
      logic [31:0] e;
      if (rdPhase && hreadyout === 1'b1 && expQ.size() > 0)
      begin
         e = expQ.pop_front();
         `CHK(hrdata, e)
         `CHK(hresp, PIB_HRESP_OKAY)
         `CHK(hreadyout, 1'b1)
      end
      rdPhase <= hsel && htrans == PIB_HTRANS_NONSEQ && !hwrite;
   end
   // Watchdog against a hung run.
   initial
   begin
      repeat (20000) @(posedge ref_clk);
      errCount++;
      tally_and_finish();
   end
   // ***************************************************************
   // Main sequence
   // ***************************************************************
   initial
   begin
      {ref_clk, hsel, hwrite, htrans, haddr, hwdata} = '0;
      {fireReq, errCount, comparisons} = '0;
      sys_rst    = 1'b1;
      hsize      = 3'h2;
      capcmpMode = PIB_CC_CAPTURE;
      seed       = 32'h00000005;
      repeat (16) @(posedge ref_clk);
      sys_rst <= 1'b0;
      rd(PIB_OFS_FLAGS, 32'h0);
      rd(PIB_OFS_ENABLES, 32'h0);
      rd(8'h40, 32'h0);
      wr(PIB_OFS_ENABLES, 32'hFFFFFFFF);
      rd(PIB_OFS_ENABLES, {24'h0, PIB_IMPL_MASK});
      wr(PIB_OFS_FLAGS, 32'hFFFFFFFF);
      rd(PIB_OFS_FLAGS, {24'h0, PIB_IMPL_MASK});
      wr(PIB_OFS_FLAGS, 32'h0);
      wr(PIB_OFS_ENABLES, 32'h0);
      // Each source: flag, enable gating, group and global gating.
      foreach (bitTab[k])
      begin
         fire(8'h01 << bitTab[k]);
         rd(PIB_OFS_FLAGS, 32'h1 << bitTab[k]);
         irqChk(1'b0);
         wr(PIB_OFS_GCTRL, 32'hC0);
         wr(PIB_OFS_ENABLES, {24'h0, PIB_IMPL_MASK} & ~(32'h1 << bitTab[k]));
         irqChk(1'b0);
         wr(PIB_OFS_ENABLES, 32'h1 << bitTab[k]);
         irqChk(1'b1);
         wr(PIB_OFS_GCTRL, 32'h80);
         irqChk(1'b0);
         wr(PIB_OFS_GCTRL, 32'h40);
         irqChk(1'b0);
         rd(PIB_OFS_FLAGS, 32'h1 << bitTab[k]);
         wr(PIB_OFS_GCTRL, 32'h0);
         wr(PIB_OFS_FLAGS, 32'h0);
         rd(PIB_OFS_FLAGS, 32'h0);
         wr(PIB_OFS_ENABLES, 32'h0);
      end
      // Capture/compare events are ignored in pulse-width mode.
      capcmpMode <= PIB_CC_PWM;
      fire(8'h04);
      rd(PIB_OFS_FLAGS, 32'h0);
      // Random enables and simultaneous events.
      repeat (4)
      begin
         v = xs();
         capcmpMode <= v[8] ? PIB_CC_COMPARE : PIB_CC_CAPTURE;
         wr(PIB_OFS_ENABLES, v);
         rd(PIB_OFS_ENABLES, v & 32'hCF);
         fire(v[7:0]);
         rd(PIB_OFS_FLAGS, v & 32'hCF);
         wr(PIB_OFS_FLAGS, 32'h0);
      end
      // Events in the data phase of a clearing write win over it.
      capcmpMode <= PIB_CC_COMPARE;
      fork
         wr(PIB_OFS_FLAGS, 32'h0);
         fire(8'h0C);
      join
      rd(PIB_OFS_FLAGS, 32'h0C);
      repeat (2) @(posedge ref_clk);
      `CHK(expQ.size(), 0)
      tally_and_finish();
   end
endmodule // peripheral_irq_enable_flag_bank_tb_top
`default_nettype wire
